// ### verilog/nor_host_ctrl.sv
// Host controller that drives an asynchronous parallel NOR flash over its pins.
// Assumes a single 200 MHz clock; flash pins sampled through two flip-flops.
//
// Overview of operation
// - Host holds width select steady during writes
// - Reset held minimum pulse resets device control
// - Host waits reset recovery before any access
// - Host ignores bits 14:8 when polling status
// - Read: address, select and output enable low
// - Output enable high through every write
`timescale 1ns/1ps
module nor_host_ctrl
(
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic ARST_N_I,
  // Request side
  input wire logic REQ_VALID_I,
  output logic REQ_READY_O,
  input wire nor_host_pkg::req_t REQ_I,
  // Read answer side
  output logic RSP_VALID_O,
  input wire logic RSP_READY_I,
  output nor_host_pkg::rsp_t RSP_O,
  // Controls
  input wire logic RESET_FLASH_I,
  input wire logic WRITE_PROTECT_I,
  output logic FLASH_READY_O,
  output logic FLASH_BUSY_O,
  // Flash pins
  output logic CHIP_SEL_N_O,
  output logic OUT_EN_N_O,
  output logic WRITE_EN_N_O,
  output logic RESET_N_O,
  output logic WRITE_PROT_N_O,
  output logic WIDTH_SEL_O,
  output logic [nor_host_pkg::ADDR_W-1:0] ADDR_O,
  input wire logic [nor_host_pkg::DATA_W-2:0] DATA_I,
  output logic [nor_host_pkg::DATA_W-2:0] DATA_O,
  output logic [nor_host_pkg::DATA_W-2:0] DATA_OE_O,
  input wire logic TOP_DATA_OR_LSB_ADDR_I,
  output logic TOP_DATA_OR_LSB_ADDR_O,
  output logic TOP_DATA_OR_LSB_ADDR_OE_O,
  input wire logic READY_BUSY_OD_I
);
  import nor_host_pkg::*;

  typedef enum logic [7:0] {
    S_RESET = 8'h01,
    S_RECOVER = 8'h02,
    S_IDLE = 8'h04,
    S_RD_WAIT = 8'h08,
    S_RD_DONE = 8'h10,
    S_WR_SETUP = 8'h20,
    S_WR_PULSE = 8'h40,
    S_WR_HOLD = 8'h80
  } state_t;

  state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  req_t cur, next_cur;
  logic cs_n, next_cs_n, oe_n, next_oe_n, we_n, next_we_n, drive, next_drive;
  logic [DATA_W-1:0] rbuf, next_rbuf;
  logic buf_valid, buf_ready;
  logic [DATA_W-1:0] din_meta, din_sync;
  logic rb_meta, rb_sync;
  rsp_t buf_in;

  // Pins pass two flip-flops before use
  always_ff @(posedge CLOCK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      din_meta <= '0;
      din_sync <= '0;
      rb_meta <= 1'b1;
      rb_sync <= 1'b1;
    end
    else
    begin
      din_meta <= {TOP_DATA_OR_LSB_ADDR_I, DATA_I};
      din_sync <= din_meta;
      rb_meta <= READY_BUSY_OD_I;
      rb_sync <= rb_meta;
    end
  end

  assign FLASH_BUSY_O = ~rb_sync;
  assign FLASH_READY_O = (state == S_IDLE);
  // Width select changes only when a request is taken, so never mid-write
  assign REQ_READY_O = (state == S_IDLE);
  assign buf_in.rdata = rbuf;
  assign buf_valid = (state == S_RD_DONE);

  always_comb
  begin
    next_state = state;
    next_cnt = (cnt == '0) ? cnt : cnt - 1'b1;
    next_cur = cur;
    next_cs_n = cs_n;
    next_oe_n = oe_n;
    next_we_n = we_n;
    next_drive = drive;
    next_rbuf = rbuf;
    case (state)
      S_RESET:
      begin
        next_cs_n = 1'b1;
        if (cnt == '0 && !RESET_FLASH_I)
        begin
          next_state = S_RECOVER;
          next_cnt = CNT_W'(RECOVER_CYC);
        end
      end
      S_RECOVER:
      begin
        if (cnt == '0)
          next_state = S_IDLE;
      end
      S_IDLE:
      begin
        if (REQ_VALID_I)
        begin
          next_cur = REQ_I;
          next_cs_n = 1'b0;
          if (REQ_I.write)
          begin
            next_oe_n = 1'b1;
            next_drive = 1'b1;
            next_state = S_WR_SETUP;
            next_cnt = CNT_W'(SETUP_CYC);
          end
          else
          begin
            next_oe_n = 1'b0;
            next_we_n = 1'b1;
            next_state = S_RD_WAIT;
            next_cnt = CNT_W'(ACCESS_CYC);
          end
        end
      end
      S_RD_WAIT:
      begin
        if (cnt == '0)
        begin
          // Status polls keep only bit 15 and the low byte in x16, only the low byte in x8
          next_rbuf = cur.poll ? (din_sync & POLL_MASK_X16) : din_sync;
          if (!cur.word_mode)
            next_rbuf = {8'h00, din_sync[7:0]};
          next_oe_n = 1'b1;
          next_cs_n = 1'b1;
          next_state = S_RD_DONE;
        end
      end
      S_RD_DONE:
      begin
        if (buf_ready)
          next_state = S_IDLE;
      end
      S_WR_SETUP:
      begin
        if (cnt == '0)
        begin
          // Address is stable before this fall of write enable
          next_we_n = 1'b0;
          next_state = S_WR_PULSE;
          next_cnt = CNT_W'(WRITE_PULSE_CYC);
        end
      end
      S_WR_PULSE:
      begin
        if (cnt == '0)
        begin
          // Data held across the rise, released WRITE_HIGH_CYC + 1 cycles later
          next_we_n = 1'b1;
          next_state = S_WR_HOLD;
          next_cnt = CNT_W'(WRITE_HIGH_CYC);
        end
      end
      S_WR_HOLD:
      begin
        if (cnt == '0)
        begin
          next_drive = 1'b0;
          next_cs_n = 1'b1;
          next_state = S_IDLE;
        end
      end
      default:
        next_state = S_RESET;
    endcase
    if (RESET_FLASH_I && state != S_RESET)
    begin
      next_state = S_RESET;
      next_cnt = CNT_W'(MIN_RESET_PULSE_CYC);
      next_cs_n = 1'b1;
      next_oe_n = 1'b1;
      next_we_n = 1'b1;
      next_drive = 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      state <= S_RESET;
      cnt <= CNT_W'(MIN_RESET_PULSE_CYC);
      cur <= '0;
      cs_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      drive <= 1'b0;
      rbuf <= '0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      cur <= next_cur;
      cs_n <= next_cs_n;
      oe_n <= next_oe_n;
      we_n <= next_we_n;
      drive <= next_drive;
      rbuf <= next_rbuf;
    end
  end

  // Strobe and address pins come from flip-flops; write protect follows its input directly
  assign CHIP_SEL_N_O = cs_n;
  assign OUT_EN_N_O = oe_n;
  assign WRITE_EN_N_O = we_n;
  assign RESET_N_O = (state != S_RESET);
  assign WRITE_PROT_N_O = ~WRITE_PROTECT_I;
  assign WIDTH_SEL_O = cur.word_mode;
  assign ADDR_O = cur.addr;
  // Only the low byte carries commands in x8; upper bits never driven then
  assign DATA_O = cur.wdata[DATA_W-2:0];
  assign DATA_OE_O = {{7{drive && cur.word_mode}}, {8{drive}}};
  // Top pin is the address LSB in x8, so driven always in that mode
  assign TOP_DATA_OR_LSB_ADDR_O = cur.word_mode ? cur.wdata[DATA_W-1] : cur.addr[0];
  assign TOP_DATA_OR_LSB_ADDR_OE_O = cur.word_mode ? drive : 1'b1;

  nor_rsp_buffer u_rsp_buffer
  (
    .clk_i(CLOCK_I),
    .arst_n_i(ARST_N_I),
    .in_valid_i(buf_valid),
    .in_ready_o(buf_ready),
    .in_data_i(buf_in),
    .out_valid_o(RSP_VALID_O),
    .out_ready_i(RSP_READY_I),
    .out_data_o(RSP_O)
  );
endmodule

// ### verilog/nor_host_pkg.sv
// Constants, types and timing for the parallel flash host controller.
// Assumes a 200 MHz system clock; all pin timing is counted in its cycles.
package nor_host_pkg;
  localparam int ADDR_W = 25;
  localparam int DATA_W = 16;
  localparam int CLK_PERIOD_PS = 5000;
  // Times in ns, converted to cycles below
  localparam int MIN_RESET_PULSE_NS = 50;
  localparam int RESET_TO_SELECT_DELAY_NS = 50;
  localparam int RESET_TO_WRITE_DELAY_NS = 50;
  localparam int ACCESS_NS = 110;
  localparam int WRITE_PULSE_NS = 35;
  localparam int WRITE_HIGH_NS = 20;
  localparam int SETUP_NS = 10;
  // Least times round up
  localparam int MIN_RESET_PULSE_CYC = (MIN_RESET_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RECOVER_NS = (RESET_TO_SELECT_DELAY_NS > RESET_TO_WRITE_DELAY_NS) ?
    RESET_TO_SELECT_DELAY_NS : RESET_TO_WRITE_DELAY_NS;
  localparam int RECOVER_CYC = (RECOVER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ACCESS_CYC = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WRITE_HIGH_CYC = (WRITE_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SETUP_CYC = (SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 8;
  localparam logic [15:0] POLL_MASK_X16 = 16'h80ff;

  typedef struct packed {
    logic write;
    logic word_mode;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic poll;
  } req_t;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
  } rsp_t;
endpackage

// ### verilog/nor_rsp_buffer.sv
// Two-entry valid/ready buffer for read results.
// Assumes both sides on the same clock.
`timescale 1ns/1ps
module nor_rsp_buffer
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire nor_host_pkg::rsp_t in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output nor_host_pkg::rsp_t out_data_o
);
  import nor_host_pkg::*;
  rsp_t mem [2];
  logic wptr, rptr;
  logic [1:0] count;
  logic next_wptr, next_rptr;
  logic [1:0] next_count;
  logic push, pop;

  assign in_ready_o = (count != 2'h2);
  assign out_valid_o = (count != 2'h0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb
  begin
    next_wptr = push ? ~wptr : wptr;
    next_rptr = pop ? ~rptr : rptr;
    next_count = count + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wptr <= 1'b0;
      rptr <= 1'b0;
      count <= 2'h0;
      mem[0] <= '0;
      mem[1] <= '0;
      out_data_o <= '0;
    end
    else
    begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      count <= next_count;
      if (push)
        mem[wptr] <= in_data_i;
      out_data_o <= mem[next_rptr];
      if (push && (next_count == 2'h1 || (count == 2'h1 && pop)) && wptr == next_rptr)
        out_data_o <= in_data_i;
    end
  end
endmodule

// ### tb/nor_flash_model.sv
// Behavioural flash device on the far side of the host controller pins.
// Assumes a pull-up on ready/busy; released data lines show the inverse.
`timescale 1ns/1ps
module nor_flash_model
(
  // Controls
  input wire logic cs_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic rst_n_i,
  input wire logic width_i,
  // Address and data
  input wire logic [24:0] addr_i,
  input wire logic [14:0] dq_i,
  input wire logic top_i,
  output logic [14:0] dq_o,
  output logic top_o,
  output logic rb_o
);
  logic [15:0] word;
  logic [15:0] wd;
  logic [24:0] wa;
  logic busy;
  logic rd_on;
  // Slow access; undriven lines never keep a stale copy
  assign #100 word = (width_i ? addr_i[15:0] : {addr_i[14:0], top_i}) ^ 16'h3c5a;
  assign rd_on = !cs_n_i && !oe_n_i && we_n_i && rst_n_i;
  assign dq_o[7:0] = rd_on ? word[7:0] : ~word[7:0];
  assign dq_o[14:8] = (rd_on && width_i) ? word[14:8] : ~word[14:8];
  assign top_o = (rd_on && width_i) ? word[15] : ~word[15];
  assign rb_o = !busy;
  initial busy = 1'b0;
  always @(negedge we_n_i)
    if (!cs_n_i)
      wa = addr_i;
  always @(posedge we_n_i)
    if (!cs_n_i && rst_n_i)
    begin
      wd = {top_i, dq_i};
      busy = 1'b1;
      #200 busy = 1'b0;
    end
  always @(negedge rst_n_i)
    busy = 1'b0;
endmodule

// ### tb/nor_host_ctrl_chk.sv
// Pin-protocol checker for the flash host controller.
// Assumes it is bound to the controller and sees its ports only.
`timescale 1ns/1ps
module nor_host_ctrl_chk
(
  // Clock, reset, inputs
  input wire logic CLOCK_I,
  input wire logic ARST_N_I,
  input wire logic WRITE_PROTECT_I,
  // Request ready and flash pins
  input wire logic REQ_READY_O,
  input wire logic CHIP_SEL_N_O,
  input wire logic OUT_EN_N_O,
  input wire logic WRITE_EN_N_O,
  input wire logic RESET_N_O,
  input wire logic WRITE_PROT_N_O,
  input wire logic WIDTH_SEL_O,
  input wire logic [nor_host_pkg::DATA_W-2:0] DATA_OE_O,
  input wire logic TOP_DATA_OR_LSB_ADDR_OE_O
);
  import nor_host_pkg::*;
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!ARST_N_I);
  a_read_we_high: assert property (!OUT_EN_N_O |-> !CHIP_SEL_N_O && WRITE_EN_N_O)
    else $error("read without select or with write strobe");
  a_write_oe_high: assert property (!WRITE_EN_N_O |-> OUT_EN_N_O && !CHIP_SEL_N_O)
    else $error("write strobe with output enable low");
  a_width_steady: assert property (!CHIP_SEL_N_O && $past(!CHIP_SEL_N_O) |-> $stable(WIDTH_SEL_O))
    else $error("width select moved inside an access");
  a_reset_pulse: assert property ($fell(RESET_N_O) |=> !RESET_N_O [*8] ##1 !RESET_N_O)
    else $error("flash reset pulse too short");
  a_reset_idle: assert property (!RESET_N_O |-> CHIP_SEL_N_O && WRITE_EN_N_O && !REQ_READY_O)
    else $error("access during flash reset");
  a_recover_wait: assert property ($rose(RESET_N_O) |-> (CHIP_SEL_N_O && !REQ_READY_O) [*5] ##1
    (CHIP_SEL_N_O && !REQ_READY_O) [*5])
    else $error("access before reset recovery");
  a_protect_pin: assert property (WRITE_PROT_N_O == !WRITE_PROTECT_I)
    else $error("write protect pin wrong");
  a_byte_lsb_out: assert property (!CHIP_SEL_N_O && !WIDTH_SEL_O |-> TOP_DATA_OR_LSB_ADDR_OE_O)
    else $error("address lsb not driven in byte mode");
  a_no_bus_clash: assert property (!OUT_EN_N_O |-> DATA_OE_O == '0)
    else $error("host drives data while flash outputs");
  a_no_top_clash: assert property (!OUT_EN_N_O && WIDTH_SEL_O |-> !TOP_DATA_OR_LSB_ADDR_OE_O)
    else $error("host drives top data bit while flash outputs");
endmodule

// ### tb/nor_host_ctrl_tb_top.sv
// Self-checking bench: controller against a behavioural flash device.
// Assumes a 200 MHz clock; inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
module nor_host_ctrl_tb_top;
  import nor_host_pkg::*;
  logic CLOCK_I, ARST_N_I, REQ_VALID_I, REQ_READY_O, RSP_VALID_O, RSP_READY_I;
  logic RESET_FLASH_I, WRITE_PROTECT_I, FLASH_READY_O, FLASH_BUSY_O, READY_BUSY_OD_I;
  logic CHIP_SEL_N_O, OUT_EN_N_O, WRITE_EN_N_O, RESET_N_O, WRITE_PROT_N_O, WIDTH_SEL_O;
  logic TOP_DATA_OR_LSB_ADDR_I, TOP_DATA_OR_LSB_ADDR_O, TOP_DATA_OR_LSB_ADDR_OE_O, top_dev;
  logic [ADDR_W-1:0] ADDR_O;
  logic [DATA_W-2:0] DATA_I, DATA_O, DATA_OE_O, dq_dev;
  req_t REQ_I;
  rsp_t RSP_O;
  int mismatches, total_checks, cyc, n;
  nor_host_ctrl nor_host_ctrl_i (.*);
  nor_flash_model nor_flash_model_i (.cs_n_i(CHIP_SEL_N_O), .oe_n_i(OUT_EN_N_O), .we_n_i(WRITE_EN_N_O),
    .rst_n_i(RESET_N_O), .width_i(WIDTH_SEL_O), .addr_i(ADDR_O), .dq_i(DATA_I),
    .top_i(TOP_DATA_OR_LSB_ADDR_I), .dq_o(dq_dev), .top_o(top_dev), .rb_o(READY_BUSY_OD_I));
  assign DATA_I = (DATA_OE_O & DATA_O) | (~DATA_OE_O & dq_dev);
  assign TOP_DATA_OR_LSB_ADDR_I = TOP_DATA_OR_LSB_ADDR_OE_O ? TOP_DATA_OR_LSB_ADDR_O : top_dev;
  initial
  begin
    CLOCK_I = 1'b0;
    forever #2.5 CLOCK_I = ~CLOCK_I;
  end
  function automatic logic [15:0] pat(input logic [15:0] a);
    return a ^ 16'h3c5a;
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge CLOCK_I);
    #1;
  endtask
  task automatic req(input logic w, input logic wm, input logic p, input logic [24:0] a, input logic [15:0] d);
    REQ_I = '{w, wm, a, d, p};
    REQ_VALID_I = 1'b1;
    for (n = 0; n < 500 && REQ_READY_O !== 1'b1; n++) tick(1);
    if (n == 500)
      mismatches++;
    tick(1);
    REQ_VALID_I = 1'b0;
    // One idle edge so a following request never re-raises valid in this step
    tick(1);
  endtask
  task automatic drain(input logic [15:0] exp);
    for (n = 0; n < 500 && RSP_VALID_O !== 1'b1; n++) tick(1);
    if (n == 500)
      mismatches++;
    RSP_READY_I = 1'b1;
    chk("read data", exp, RSP_O.rdata);
    tick(1);
    RSP_READY_I = 1'b0;
    tick(1);
  endtask
  task automatic t_reads();
    req(0, 1, 0, 25'h1234, 0);
    drain(pat(16'h1234));
    // Low 16 bits alike, so the byte address reads the same however it is split
    req(0, 0, 0, 25'h0, 0);
    drain(16'h00ff & pat(16'h0000));
    req(0, 0, 0, 25'h1ffffff, 0);
    drain(16'h00ff & pat(16'hffff));
    req(0, 1, 1, 25'h1234, 0);
    drain(16'h80ff & pat(16'h1234));
  endtask
  task automatic t_writes();
    req(1, 1, 0, 25'h0aaa, 16'h8055);
    tick(20);
    chk("write addr", 25'h0aaa, nor_flash_model_i.wa);
    chk("write data", 16'h8055, nor_flash_model_i.wd);
    chk("busy", 1, FLASH_BUSY_O);
    tick(60);
    chk("idle", 0, FLASH_BUSY_O);
    req(1, 0, 0, 25'h555, 16'h12a0);
    tick(20);
    chk("write byte", 8'ha0, nor_flash_model_i.wd[7:0]);
  endtask
  task automatic t_stall();
    req(0, 1, 0, 25'h1, 0);
    req(0, 1, 0, 25'h2, 0);
    req(0, 1, 0, 25'h3, 0);
    tick(40);
    chk("stall", 0, REQ_READY_O);
    drain(pat(16'h1));
    drain(pat(16'h2));
    drain(pat(16'h3));
  endtask
  task automatic t_reset();
    req(1, 1, 0, 25'h0aaa, 16'h80aa);
    tick(15);
    RESET_FLASH_I = 1'b1;
    tick(3);
    chk("reset pin", 0, RESET_N_O);
    chk("ready in reset", 0, FLASH_READY_O);
    RESET_FLASH_I = 1'b0;
    for (n = 0; n < 200 && REQ_READY_O !== 1'b1; n++) tick(1);
    chk("recovery", 1, n >= 17);
    chk("flash ready", 1, FLASH_READY_O);
    chk("busy cleared", 0, FLASH_BUSY_O);
    WRITE_PROTECT_I = 1'b1;
    tick(1);
    chk("protect", 0, WRITE_PROT_N_O);
    WRITE_PROTECT_I = 1'b0;
    tick(1);
    chk("unprotect", 1, WRITE_PROT_N_O);
  endtask
  initial
  begin
    ARST_N_I = 1'b0;
    REQ_VALID_I = 1'b0;
    REQ_I = '0;
    RSP_READY_I = 1'b0;
    RESET_FLASH_I = 1'b0;
    WRITE_PROTECT_I = 1'b0;
    tick(20);
    ARST_N_I = 1'b1;
    t_reads();
    t_writes();
    t_stall();
    t_reset();
    finish_test();
  end
  // Whole run needs a few hundred cycles
  always @(posedge CLOCK_I)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      finish_test();
    end
  end
endmodule
bind nor_host_ctrl nor_host_ctrl_chk nor_host_ctrl_chk_i (.CLOCK_I, .ARST_N_I, .WRITE_PROTECT_I, .REQ_READY_O,
  .CHIP_SEL_N_O, .OUT_EN_N_O, .WRITE_EN_N_O, .RESET_N_O, .WRITE_PROT_N_O, .WIDTH_SEL_O, .DATA_OE_O,
  .TOP_DATA_OR_LSB_ADDR_OE_O);
